// File: include/snap_pkg.sv
// Notes on behaviour
// - scale-monitor readback is read-only 4 bytes: turn-on offset high, turn-off scale low.
// - slew limits are R/W 8 bytes, four signed 16-bit limits, input positive first.
// - pre-bias start allowed only while input slope lies within both input limits.
// - pre-bias start allowed only while output slope lies within both output limits.
// - filter selector R/W byte: 0 output voltage, 1 output current, 2 feed-forward.
// - snapshot readback is read-only block of exactly 32 bytes.
// - input loss during conversion stores the snapshot to non-volatile memory automatically.
// - commanded off before input loss: all snapshot bytes except counter read ones.
// - top snapshot field is a 16-bit unsigned shutdown counter.
// - then fault-count byte, seven status byte copies, then 16-bit status word.
// - snapshot holds previous power-cycle duration in whole seconds.
// - snapshot holds chosen and unchosen sensor temperatures in linear format.
// - lower half: chosen temperature, load current, output and input voltage now, plus earlier duty/current/volts.
// - temperature-compensation parameters are a read-only 8-byte block.
package snap_pkg;
   localparam logic [7:0] CMD_SCALE_MON  = 8'hd3;
   localparam logic [7:0] CMD_SLEW_LIM   = 8'hd4;
   localparam logic [7:0] CMD_FILTER_SEL = 8'hd5;
   localparam logic [7:0] CMD_SNAPSHOT   = 8'hd7;
   localparam logic [7:0] CMD_THERM_COMP = 8'hd8;
   localparam logic [5:0] LEN_SCALE_MON  = 6'h04;
   localparam logic [5:0] LEN_SLEW_LIM   = 6'h08;
   localparam logic [5:0] LEN_FILTER_SEL = 6'h01;
   localparam logic [5:0] LEN_SNAPSHOT   = 6'h20;
   localparam logic [5:0] LEN_THERM_COMP = 6'h08;
   localparam logic [7:0] FILT_VOUT      = 8'h00;
   localparam logic [7:0] FILT_IOUT      = 8'h01;
   localparam logic [7:0] FILT_FEED_FWD  = 8'h02;
   localparam logic [7:0] ERASED_BYTE    = 8'hff;
   localparam logic [63:0] SLEW_RESET    = 64'h0000_0000_0000_0000;
   localparam logic [7:0] FILTER_RESET   = 8'h00;
   localparam int SNAP_CNT_LSB           = 240;
   localparam int SEC_CYCLES             = 10_000_000;
   // block transfer widths
   localparam int SNAP_BITS              = 256;
   typedef logic [SNAP_BITS-1:0] snap_t;
   typedef struct packed {
      logic [15:0] status_word;
      logic [7:0]  st_byte;
      logic [7:0]  st_vout;
      logic [7:0]  st_iout;
      logic [7:0]  st_vin;
      logic [7:0]  st_temp;
      logic [7:0]  comm_logic_status;
      logic [7:0]  st_other;
   } status_s;
   typedef struct packed {
      logic [15:0] iout;
      logic [15:0] vout;
      logic [15:0] vin;
      logic [15:0] duty;
      logic [15:0] temp_sel;
      logic [15:0] temp_other;
   } meas_s;
endpackage

// File: include/nvm_if.sv
`timescale 1ns/1ps
// carries the non-volatile snapshot store port
interface nvm_if;
   logic                 wr;
   snap_pkg::snap_t      wdata;
   snap_pkg::snap_t      rdata;
   modport host (output wr, output wdata, input rdata);
   modport mem  (input wr, input wdata, output rdata);
endinterface

// File: hdl/snap_store.sv
`timescale 1ns/1ps
module snap_store (
   // clock and reset
   input  wire logic clock_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   // store port
   nvm_if.mem        port
);
   typedef struct packed {
      snap_pkg::snap_t rec;
   } st_s;
   st_s st_ff;
   st_s nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      // record only changes on a capture write, reads never disturb it
      if (port.wr)
      begin
         nxt_st.rec = port.wdata;
      end
   end
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         st_ff <= '1;
      else if (ce_in)
         st_ff <= nxt_st;
   end
   assign port.rdata = st_ff.rec;
endmodule

// File: hdl/slew_check.sv
`timescale 1ns/1ps
module slew_check (
   // clock and reset
   input  wire logic               clock_in,
   input  wire logic               rst_in,
   input  wire logic               ce_in,
   // sample and limits
   input  wire logic               tick_in,
   input  wire logic signed [15:0] sample_in,
   input  wire logic signed [15:0] pos_lim_in,
   input  wire logic signed [15:0] neg_lim_in,
   output logic                    ok_out
);
   typedef struct packed {
      logic signed [15:0] last;
      logic               ok;
   } st_s;
   st_s st_ff;
   st_s nxt_st;
   logic signed [16:0] delta;
   always_comb
   begin
      nxt_st = st_ff;
      delta  = 17'(sample_in) - 17'(st_ff.last);
      if (tick_in)
      begin
         // negative limit is given as a signed value, compared as a floor
         nxt_st.ok   = (delta <= 17'(pos_lim_in)) && (delta >= 17'(neg_lim_in));
         nxt_st.last = sample_in;
      end
   end
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         st_ff <= '0;
      else if (ce_in)
         st_ff <= nxt_st;
   end
   assign ok_out = st_ff.ok;
endmodule

// File: hdl/powerloss_snapshot_and_config_cmds.sv
`timescale 1ns/1ps
module powerloss_snapshot_and_config_cmds #(
   parameter int SEC_CYCLES = snap_pkg::SEC_CYCLES
) (
   // clock and reset
   input  wire logic                    clock_in,
   input  wire logic                    rst_in,
   input  wire logic                    ce_in,
   // command port from the management-bus engine
   input  wire logic                    cmd_start_in,
   input  wire logic [7:0]              cmd_code_in,
   input  wire logic                    wr_byte_in,
   input  wire logic [7:0]              wr_data_in,
   input  wire logic                    rd_byte_in,
   output logic [7:0]                   rd_data_out,
   output logic [5:0]                   blk_len_out,
   output logic                         cmd_err_out,
   // controller state
   input  wire logic [15:0]             scale_on_in,
   input  wire logic [15:0]             scale_off_in,
   input  wire logic [63:0]             therm_comp_in,
   input  wire logic                    converting_in,
   input  wire logic                    vin_lost_in,
   input  wire logic                    cmd_off_in,
   input  wire logic                    fault_in,
   input  wire logic                    shutdown_in,
   input  wire logic                    sample_tick_in,
   input  wire snap_pkg::status_s       status_in,
   input  wire snap_pkg::meas_s         meas_in,
   input  wire snap_pkg::meas_s         meas_old_in,
   // outputs to the controller
   output logic [7:0]                   filter_sel_out,
   output logic                         prebias_ok_out,
   output logic                         capture_out
);
   typedef enum {IDLE, READ, WRITE} phase_e;
   typedef struct packed {
      phase_e           phase;
      logic [7:0]       cmd;
      logic [5:0]       idx;
      logic [63:0]      slew;
      logic [63:0]      slew_shadow;
      logic [7:0]       filter;
      logic [15:0]      shut_cnt;
      logic [7:0]       fault_cnt;
      logic [31:0]      sec_cnt;
      logic [15:0]      secs;
      logic             ran_up;
      logic             was_off;
      logic             conv_d;
      logic             lost_d;
      logic [7:0]       rd_data;
      logic [5:0]       blk_len;
      logic             err;
      logic             pb_ok;
      logic             cap;
   } st_s;
   st_s st_ff;
   st_s nxt_st;
   nvm_if nvm ();
   logic vin_ok;
   logic vout_ok;
   snap_pkg::snap_t cap_rec;
   function automatic logic [5:0] len_of(input logic [7:0] code);
      case (code)
         snap_pkg::CMD_SCALE_MON:  len_of = snap_pkg::LEN_SCALE_MON;
         snap_pkg::CMD_SLEW_LIM:   len_of = snap_pkg::LEN_SLEW_LIM;
         snap_pkg::CMD_FILTER_SEL: len_of = snap_pkg::LEN_FILTER_SEL;
         snap_pkg::CMD_SNAPSHOT:   len_of = snap_pkg::LEN_SNAPSHOT;
         snap_pkg::CMD_THERM_COMP: len_of = snap_pkg::LEN_THERM_COMP;
         default:                  len_of = '0;
      endcase
   endfunction
   function automatic logic writable(input logic [7:0] code);
      writable = (code == snap_pkg::CMD_SLEW_LIM) || (code == snap_pkg::CMD_FILTER_SEL);
   endfunction
   // bytes leave most significant first
   function automatic logic [7:0] pick(input snap_pkg::snap_t v, input logic [5:0] n,
                                       input logic [5:0] i);
      logic [8:0] sh;
      sh   = 9'((n - i - 6'h01)) << 3;
      pick = 8'(v >> sh);
   endfunction
   slew_check u_vin_slew (
      .clock_in   (clock_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .tick_in    (sample_tick_in),
      .sample_in  (meas_in.vin),
      .pos_lim_in (st_ff.slew[63:48]),
      .neg_lim_in (st_ff.slew[47:32]),
      .ok_out     (vin_ok)
   );
   slew_check u_vout_slew (
      .clock_in   (clock_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .tick_in    (sample_tick_in),
      .sample_in  (meas_in.vout),
      .pos_lim_in (st_ff.slew[31:16]),
      .neg_lim_in (st_ff.slew[15:0]),
      .ok_out     (vout_ok)
   );
   snap_store u_store (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .ce_in    (ce_in),
      .port     (nvm.mem)
   );
   always_comb
   begin
      // record layout, counter on top
      // the cycle that ends with this capture is the previous one when read back
      cap_rec = {st_ff.shut_cnt, st_ff.fault_cnt,
                 status_in.st_other, status_in.comm_logic_status, status_in.st_temp,
                 status_in.st_vin, status_in.st_iout, status_in.st_vout, status_in.st_byte,
                 status_in.status_word, st_ff.secs,
                 meas_in.temp_other, meas_in.temp_sel, meas_in.iout,
                 meas_in.vout, meas_in.vin, meas_old_in.duty, meas_old_in.iout,
                 meas_old_in.vout, meas_old_in.vin};
      if (st_ff.was_off)
      begin
         // commanded off earlier: everything but the counter reads erased
         cap_rec[snap_pkg::SNAP_CNT_LSB-1:0] = '1;
      end
   end
   assign nvm.wr    = st_ff.cap;
   assign nvm.wdata = cap_rec;
   always_comb
   begin
      nxt_st         = st_ff;
      nxt_st.cap     = 1'b0;
      nxt_st.conv_d  = converting_in;
      nxt_st.lost_d  = vin_lost_in;
      nxt_st.pb_ok   = vin_ok && vout_ok;
      if (fault_in)
         nxt_st.fault_cnt = st_ff.fault_cnt + 8'h01;
      if (shutdown_in)
         nxt_st.shut_cnt = st_ff.shut_cnt + 16'h0001;
      if (converting_in)
         nxt_st.ran_up = 1'b1;
      if (cmd_off_in && st_ff.ran_up)
         nxt_st.was_off = 1'b1;
      // seconds of the running power cycle
      if (st_ff.sec_cnt == 32'(SEC_CYCLES - 1))
      begin
         nxt_st.sec_cnt = '0;
         nxt_st.secs    = st_ff.secs + 16'h0001;
      end
      else
         nxt_st.sec_cnt = st_ff.sec_cnt + 32'h1;
      // capture on rising loss edge, either while converting or after command-off
      if (vin_lost_in && !st_ff.lost_d && (st_ff.conv_d || st_ff.was_off))
      begin
         nxt_st.cap = 1'b1;
      end
      if (st_ff.cap)
      begin
         // new power cycle starts; events of this very cycle still count
         nxt_st.fault_cnt  = {7'h00, fault_in};
         nxt_st.secs       = '0;
         nxt_st.sec_cnt    = '0;
         nxt_st.ran_up     = converting_in;
         nxt_st.was_off    = cmd_off_in && st_ff.ran_up;
      end
      if (cmd_start_in)
      begin
         nxt_st.cmd     = cmd_code_in;
         nxt_st.idx     = '0;
         nxt_st.blk_len = len_of(cmd_code_in);
         nxt_st.err     = (len_of(cmd_code_in) == '0);
         nxt_st.phase   = IDLE;
         nxt_st.slew_shadow = st_ff.slew;
      end
      else
      begin
         case (st_ff.phase)
            IDLE, READ, WRITE:
            begin
               if (rd_byte_in && st_ff.blk_len != '0)
               begin
                  nxt_st.phase = READ;
                  // reads past the block return erased filler
                  if (st_ff.idx < st_ff.blk_len)
                  begin
                     case (st_ff.cmd)
                        snap_pkg::CMD_SCALE_MON:
                           nxt_st.rd_data = pick({192'h0, scale_on_in, scale_off_in},
                                                 st_ff.blk_len, st_ff.idx);
                        snap_pkg::CMD_SLEW_LIM:
                           nxt_st.rd_data = pick({192'h0, st_ff.slew},
                                                 st_ff.blk_len, st_ff.idx);
                        snap_pkg::CMD_FILTER_SEL:
                           nxt_st.rd_data = st_ff.filter;
                        snap_pkg::CMD_SNAPSHOT:
                           nxt_st.rd_data = pick(nvm.rdata, st_ff.blk_len,
                                                 st_ff.idx);
                        snap_pkg::CMD_THERM_COMP:
                           nxt_st.rd_data = pick({192'h0, therm_comp_in},
                                                 st_ff.blk_len, st_ff.idx);
                        default:
                           nxt_st.rd_data = snap_pkg::ERASED_BYTE;
                     endcase
                     nxt_st.idx = st_ff.idx + 6'h01;
                  end
                  else
                  begin
                     nxt_st.rd_data = snap_pkg::ERASED_BYTE;
                     nxt_st.err     = 1'b1;
                  end
               end
               else if (wr_byte_in && st_ff.blk_len != '0)
               begin
                  nxt_st.phase = WRITE;
                  // read-only blocks refuse writes
                  if (!writable(st_ff.cmd) || st_ff.idx >= st_ff.blk_len)
                     nxt_st.err = 1'b1;
                  else
                  begin
                     if (st_ff.cmd == snap_pkg::CMD_FILTER_SEL)
                        nxt_st.filter = wr_data_in;
                     else
                     begin
                        // shadow first, committed only once all eight bytes arrive
                        nxt_st.slew_shadow = {st_ff.slew_shadow[55:0], wr_data_in};
                        if (st_ff.idx == snap_pkg::LEN_SLEW_LIM - 6'h01)
                           nxt_st.slew = {st_ff.slew_shadow[55:0], wr_data_in};
                     end
                     nxt_st.idx = st_ff.idx + 6'h01;
                  end
               end
            end
            default:
               nxt_st.phase = IDLE;
         endcase
      end
   end
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_ff        <= '0;
         st_ff.phase  <= IDLE;
         st_ff.slew   <= snap_pkg::SLEW_RESET;
         st_ff.filter <= snap_pkg::FILTER_RESET;
      end
      else if (ce_in)
         st_ff <= nxt_st;
   end
   always_comb
   begin
      rd_data_out    = st_ff.rd_data;
      blk_len_out    = st_ff.blk_len;
      cmd_err_out    = st_ff.err;
      filter_sel_out = st_ff.filter;
      prebias_ok_out = st_ff.pb_ok;
      capture_out    = st_ff.cap;
   end
endmodule

// File: tb/snap_cmds_sva.sv
`timescale 1ns/1ps
module snap_cmds_sva (
   // clock and reset
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic       ce_in,
   // command port
   input wire logic       cmd_start_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic       wr_byte_in,
   input wire logic       rd_byte_in,
   input wire logic [7:0] rd_data_out,
   input wire logic [5:0] blk_len_out,
   input wire logic       cmd_err_out,
   // controller side
   input wire logic [15:0] scale_on_in,
   input wire logic       converting_in,
   input wire logic       vin_lost_in,
   input wire logic [7:0] filter_sel_out,
   input wire logic       capture_out
);
   default clocking dc @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   sequence st(logic [7:0] c);
      ce_in && cmd_start_in && cmd_code_in == c;
   endsequence
   a_len_scale: assert property (st(8'hd3) |=> blk_len_out == 6'h04)
      else $error("scale length wrong");
   a_len_slew: assert property (st(8'hd4) |=> blk_len_out == 6'h08)
      else $error("slew length wrong");
   a_len_filter: assert property (st(8'hd5) |=> blk_len_out == 6'h01)
      else $error("filter length wrong");
   a_len_snap: assert property (st(8'hd7) |=> blk_len_out == 6'h20)
      else $error("snapshot length wrong");
   a_len_therm: assert property (st(8'hd8) |=> blk_len_out == 6'h08)
      else $error("therm length wrong");
   // one idle cycle between start and first read, as a host at full pace gives
   a_scale_first_byte: assert property (st(8'hd3) ##1 !(cmd_start_in || rd_byte_in)
      ##1 (ce_in && rd_byte_in && !cmd_start_in)
      |=> rd_data_out == $past(scale_on_in[15:8])) else $error("scale byte wrong");
   // only the snapshot block is 32 bytes long
   a_ro_write_refused: assert property (ce_in && wr_byte_in && !cmd_start_in
      && blk_len_out == 6'h20 |=> cmd_err_out) else $error("write to snapshot not refused");
   a_capture_auto: assert property (ce_in && converting_in && $rose(vin_lost_in)
      && $past(ce_in && converting_in) |=> capture_out) else $error("no capture on input loss");
   a_capture_single: assert property (capture_out |=> !capture_out)
      else $error("capture pulse too long");
   a_filter_hold: assert property (!$stable(filter_sel_out) |-> $past(wr_byte_in))
      else $error("filter changed without write");
   cover property (capture_out);
   cover property (st(8'hd4) ##2 wr_byte_in);
   cover property (!$stable(filter_sel_out));
endmodule

bind powerloss_snapshot_and_config_cmds snap_cmds_sva chk (.clock_in, .rst_in, .ce_in,
   .cmd_start_in, .cmd_code_in, .wr_byte_in, .rd_byte_in, .rd_data_out, .blk_len_out,
   .cmd_err_out, .scale_on_in, .converting_in, .vin_lost_in, .filter_sel_out, .capture_out);

// File: tb/mgmt_host.sv
`timescale 1ns/1ps
module mgmt_host (
   // clock and pacing
   input  wire logic       clock_in,
   input  wire logic [31:0] gap_in,
   // command port of the device
   output logic            cmd_start_out,
   output logic [7:0]      cmd_code_out,
   output logic            wr_byte_out,
   output logic [7:0]      wr_data_out,
   output logic            rd_byte_out,
   input  wire logic [7:0] rd_data_in
);
   initial
   begin
      cmd_start_out = 1'b0;
      cmd_code_out = 8'h00;
      wr_byte_out = 1'b0;
      wr_data_out = 8'h00;
      rd_byte_out = 1'b0;
   end
   // gap_in idles between requests to act as a slow host
   task automatic start(input logic [7:0] c);
      repeat (gap_in) @(posedge clock_in);
      @(posedge clock_in);
      cmd_start_out <= 1'b1;
      cmd_code_out <= c;
      @(posedge clock_in);
      cmd_start_out <= 1'b0;
   endtask
   // block bytes leave most significant first
   task automatic wr_blk(input int n, input logic [63:0] v);
      for (int i = n - 1; i >= 0; i--)
      begin
         repeat (gap_in) @(posedge clock_in);
         @(posedge clock_in);
         wr_byte_out <= 1'b1;
         wr_data_out <= v[8*i+:8];
         @(posedge clock_in);
         wr_byte_out <= 1'b0;
         wr_data_out <= ~v[8*i+:8];
      end
      // let the answer settle before the caller looks
      @(negedge clock_in);
   endtask
   // reads n bytes as given by the caller, byte 0 on top
   task automatic rd_blk(input int n, output logic [255:0] v);
      v = '0;
      for (int i = 0; i < n; i++)
      begin
         repeat (gap_in) @(posedge clock_in);
         @(posedge clock_in);
         rd_byte_out <= 1'b1;
         @(posedge clock_in);
         rd_byte_out <= 1'b0;
         @(negedge clock_in);
         v = {v[247:0], rd_data_in};
      end
   endtask
endmodule

// File: tb/tb_powerloss_snapshot_and_config_cmds.sv
`timescale 1ns/1ps
module tb_powerloss_snapshot_and_config_cmds;
   logic clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
   logic cmd_start, wr_byte, rd_byte, err, ok, cap;
   logic [7:0] code, wdat, rdat, filt;
   logic [5:0] len;
   logic [15:0] s_on = 16'hc3a5, s_off = 16'h5a3c;
   logic [63:0] therm = 64'h0123_4567_89ab_cdef;
   logic conv = 1'b0, lost = 1'b0, off = 1'b0, flt = 1'b0, shut = 1'b0, tick = 1'b0;
   snap_pkg::status_s st = 72'hbeef_a1a2a3a4a5a6a7;
   snap_pkg::meas_s m = 96'h1111_2222_3333_4444_5555_6666, mo = 96'h7777_8888_9999_aaaa_bbbb_cccc;
   logic [255:0] v, ex;
   int gap = 0, num_errors = 0, checks_done = 0;
   typedef struct {logic [7:0] c; logic [5:0] n; logic e;} row_s;
   row_s rows [6] = '{'{8'hd3, 6'h04, 1'b0}, '{8'hd4, 6'h08, 1'b0}, '{8'hd5, 6'h01, 1'b0},
                      '{8'hd7, 6'h20, 1'b0}, '{8'hd8, 6'h08, 1'b0}, '{8'h00, 6'h00, 1'b1}};
   always #50 clock_in = ~clock_in;
   mgmt_host host (.clock_in(clock_in), .gap_in(gap), .cmd_start_out(cmd_start),
      .cmd_code_out(code), .wr_byte_out(wr_byte), .wr_data_out(wdat), .rd_byte_out(rd_byte),
      .rd_data_in(rdat));
   powerloss_snapshot_and_config_cmds #(.SEC_CYCLES(10)) dut (.clock_in(clock_in),
      .rst_in(rst_in), .ce_in(ce_in), .cmd_start_in(cmd_start), .cmd_code_in(code),
      .wr_byte_in(wr_byte), .wr_data_in(wdat), .rd_byte_in(rd_byte), .rd_data_out(rdat),
      .blk_len_out(len), .cmd_err_out(err), .scale_on_in(s_on), .scale_off_in(s_off),
      .therm_comp_in(therm), .converting_in(conv), .vin_lost_in(lost), .cmd_off_in(off),
      .fault_in(flt), .shutdown_in(shut), .sample_tick_in(tick), .status_in(st),
      .meas_in(m), .meas_old_in(mo), .filter_sel_out(filt), .prebias_ok_out(ok),
      .capture_out(cap));
   task automatic chk(input logic [255:0] g, input logic [255:0] e);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // which: 0 sample tick, 1 shutdown, 2 fault
   task automatic pulse(input int which);
      @(posedge clock_in);
      case (which)
         0: tick <= 1'b1;
         1: shut <= 1'b1;
         default: flt <= 1'b1;
      endcase
      @(posedge clock_in);
      {tick, shut, flt} <= 3'h0;
      repeat (3) @(posedge clock_in);
      @(negedge clock_in);
   endtask
   task automatic capture();
      @(posedge clock_in);
      lost <= 1'b1;
      for (int i = 0; i < 20 && cap !== 1'b1; i++) @(negedge clock_in);
      chk(cap, 1'b1);
      @(posedge clock_in);
      lost <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clock_in);
      num_errors++;
      end_of_test();
   end
   initial
   begin
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      @(negedge clock_in);
      chk({filt, ok, cap, len}, '0);
      foreach (rows[i])
      begin
         host.start(rows[i].c);
         @(negedge clock_in);
         chk({len, err}, {rows[i].n, rows[i].e});
      end
      done("lengths");
      // second pass with other inputs and a slow host
      for (int p = 0; p < 2; p++)
      begin
         gap = 2 * p;
         host.start(8'hd3);
         host.rd_blk(4, v);
         chk(v, {s_on, s_off});
         host.wr_blk(1, 64'h5a);
         chk({err, v[31:0]}, {1'b1, s_on, s_off});
         host.start(8'hd8);
         host.rd_blk(8, v);
         chk(v, therm);
         @(posedge clock_in) {s_on, s_off, therm} <= ~{s_on, s_off, therm};
      end
      gap = 0;
      host.start(8'hd4);
      host.wr_blk(8, 64'h0005_fffb_0005_fffb);
      host.start(8'hd4);
      host.rd_blk(8, v);
      chk(v, 64'h0005_fffb_0005_fffb);
      done("block rw");
      for (int f = 2; f >= 0; f--)
      begin
         host.start(8'hd5);
         host.wr_blk(1, f);
         @(negedge clock_in);
         chk(filt, f);
      end
      host.start(8'hd5);
      host.rd_blk(2, v);
      chk(err, 1'b1);
      chk(v[15:0], {snap_pkg::FILT_VOUT, snap_pkg::ERASED_BYTE});
      done("filter");
      repeat (3) pulse(0);
      chk(ok, 1'b1);
      @(posedge clock_in) m.vin <= m.vin + 16'h0064;
      pulse(0);
      chk(ok, 1'b0);
      repeat (2) pulse(0);
      chk(ok, 1'b1);
      @(posedge clock_in) m.vout <= m.vout - 16'h0064;
      pulse(0);
      chk(ok, 1'b0);
      repeat (2) pulse(0);
      @(posedge clock_in) m.vin <= m.vin - 16'h0064;
      pulse(0);
      chk(ok, 1'b0);
      done("prebias");
      host.start(8'hd7);
      host.wr_blk(1, 64'h5a);
      chk(err, 1'b1);
      host.start(8'hd7);
      host.rd_blk(32, v);
      chk(v, '1);
      // frozen clock enable: the start is not taken
      @(posedge clock_in) ce_in <= 1'b0;
      host.start(8'hd5);
      @(negedge clock_in);
      chk(len, snap_pkg::LEN_SNAPSHOT);
      @(posedge clock_in) ce_in <= 1'b1;
      repeat (2) pulse(1);
      pulse(2);
      @(posedge clock_in) conv <= 1'b1;
      capture();
      ex = {16'h0002, 8'h01, st.st_other, st.comm_logic_status, st.st_temp, st.st_vin,
            st.st_iout, st.st_vout, st.st_byte, st.status_word, 16'h0, m.temp_other,
            m.temp_sel, m.iout, m.vout, m.vin, mo.duty, mo.iout, mo.vout, mo.vin};
      for (int k = 0; k < 2; k++)
      begin
         host.start(8'hd7);
         host.rd_blk(32, v);
         chk(v[159:144] != 16'h0000, 1'b1);
         v[159:144] = 16'h0;
         chk(v, ex);
      end
      done("capture");
      @(posedge clock_in) off <= 1'b1;
      repeat (3) @(posedge clock_in);
      capture();
      host.start(8'hd7);
      host.rd_blk(32, v);
      chk(v, {16'h0002, {snap_pkg::SNAP_CNT_LSB{1'b1}}});
      done("commanded off");
      end_of_test();
   end
endmodule
